// ---- hdl/isp_pin_params.svh ----
`ifndef ISP_PIN_PARAMS_SVH
`define ISP_PIN_PARAMS_SVH

// processor-side register map
`define IO_PIN_ENABLE_OFS   8'hC7
`define PIN_EN_RT_BIT       0
`define PIN_EN_ON_BIT       1
`define PIN_EN_ISC_BIT      2
`define PIN_EN_RESET        8'h00

// port E pin positions
`define PE_MODE_SEL         0
`define PE_TEST_CLK         1
`define PE_DATA_IN          2
`define PE_DATA_OUT         3
`define PE_STATUS           4
`define PE_ERROR            5
`define PE_WIDTH            6

// scan chain geometry and instruction codes
`define IR_LEN              4
`define DR_LEN              32
`define IR_CAPTURE          4'h1
`define OP_ISC_ENABLE       4'h1
`define OP_ISC_DISABLE      4'h2
`define OP_PROGRAM          4'h3
`define OP_SECTOR_ERASE     4'h4
`define OP_FULL_ERASE       4'h5
`define OP_READ             4'h6
`define OP_VERIFY           4'h7
`define OP_CLEAR_ERROR      4'h8
`define OP_SET_SECURITY     4'h9
`define OP_SET_PROTECT      4'hA
`define OP_BYPASS           4'hF

// data register fields
`define DR_DATA_LSB         0
`define DR_DATA_W           8
`define DR_SECT_LSB         8
`define DR_SECT_W           5
`define DR_ADDR_LSB         16
`define DR_ADDR_W           16
`define DR_EXT_EN_BIT       0
`define DR_OPEN_DRAIN_BIT   1

`define SECTOR_COUNT        32

`endif

// ---- hdl/isp_pin_pkg.sv ----
`include "isp_pin_params.svh"

package isp_pin_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tap_state_e;

  typedef enum logic [1:0] {
    FOP_PROGRAM, FOP_SECTOR_ERASE, FOP_FULL_ERASE, FOP_READ
  } flash_op_e;

  typedef struct packed {
    logic                    valid;
    flash_op_e               op;
    logic [`DR_SECT_W-1:0]   sector;
    logic [`DR_ADDR_W-1:0]   addr;
    logic [`DR_DATA_W-1:0]   data;
  } flash_req_s;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } io_req_s;

endpackage

// ---- hdl/pin_sync.sv ----
`timescale 1ns/10ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_mclk,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  // no reset: a dedicated test port must not see its samples flushed by device reset
  always_ff @(posedge i_mclk)
  begin
    meta_reg <= i_async;
    o_sync   <= meta_reg;
  end

endmodule

// ---- hdl/isp_shift.sv ----
`timescale 1ns/10ps

module isp_shift #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_clear,
  input  wire logic             i_capture,
  input  wire logic             i_shift,
  input  wire logic             i_sin,
  input  wire logic [WIDTH-1:0] i_cap_data,
  output logic      [WIDTH-1:0] o_q
);

  // lsb leaves first, new bits enter at the msb
  always_ff @(posedge i_mclk)
  begin
    if (i_clear)
      o_q <= '0;
    else if (i_capture)
      o_q <= i_cap_data;
    else if (i_shift)
      o_q <= {i_sin, o_q[WIDTH-1:1]};
  end

endmodule

// ---- hdl/isp_pin_ctrl.sv ----
`timescale 1ns/10ps

module isp_pin_ctrl
  import isp_pin_pkg::*;
#(
  parameter int SECTORS = `SECTOR_COUNT
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_sys_rst,
  input  io_req_s                     i_io,
  output logic      [7:0]             o_io_rdata,
  input  wire logic                   i_nvm_pin_dedicate,
  input  wire logic                   i_pin_enable_product_term,
  input  wire logic                   i_nvm_security,
  input  wire logic [SECTORS-1:0]     i_nvm_protect,
  input  wire logic [`PE_WIDTH-1:0]   i_pe,
  output logic      [`PE_WIDTH-1:0]   o_pe,
  output logic      [`PE_WIDTH-1:0]   o_pe_oe_n,
  input  wire logic [`PE_WIDTH-1:0]   i_gpio_out,
  input  wire logic [`PE_WIDTH-1:0]   i_gpio_oe_n,
  output logic      [`PE_WIDTH-1:0]   o_gpio_in,
  output flash_req_s                  o_flash_req,
  input  wire logic                   i_flash_busy,
  input  wire logic                   i_flash_fail,
  input  wire logic [`DR_DATA_W-1:0]  i_flash_rdata,
  output logic                        o_pins_enabled
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin sampling and test clock edges

  logic [`PE_WIDTH-1:0] pe_sync;
  logic                 tck_prev_reg;
  logic                 tck_rise;
  logic                 tck_fall;

  pin_sync #(
    .WIDTH (`PE_WIDTH)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_async (i_pe),
    .o_sync  (pe_sync)
  );

  assign o_gpio_in = pe_sync;

  always_ff @(posedge i_mclk)
  begin
    tck_prev_reg <= pe_sync[`PE_TEST_CLK];
  end

  assign tck_rise = pe_sync[`PE_TEST_CLK] & ~tck_prev_reg;
  assign tck_fall = ~pe_sync[`PE_TEST_CLK] & tck_prev_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // run-time enable register and the pin enable

  logic rt_enable_reg;
  logic jtag_on;
  logic io_hit;
  logic isc_en_reg;
  logic tap_block;

  assign io_hit = i_io.sel && (i_io.addr == `IO_PIN_ENABLE_OFS);

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      rt_enable_reg <= 1'b0;
    else if (io_hit && i_io.wr)
      rt_enable_reg <= i_io.wdata[`PIN_EN_RT_BIT];
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_io_rdata <= `PIN_EN_RESET;
    else if (io_hit && i_io.rd)
    begin
      o_io_rdata                  <= `PIN_EN_RESET;
      o_io_rdata[`PIN_EN_RT_BIT]  <= rt_enable_reg;
      o_io_rdata[`PIN_EN_ON_BIT]  <= jtag_on;
      o_io_rdata[`PIN_EN_ISC_BIT] <= isc_en_reg;
    end
  end

  assign jtag_on = i_nvm_pin_dedicate | rt_enable_reg | i_pin_enable_product_term;
  assign o_pins_enabled = jtag_on;

  // reset aborts the port unless the pins are dedicated, so a board reset during
  // production programming does not corrupt a dedicated session
  assign tap_block = ~jtag_on | (i_sys_rst & ~i_nvm_pin_dedicate);

  ////////////////////////////////////////////////////////////////////////////////
  // test access controller

  tap_state_e tap_state_reg;

  function automatic tap_state_e tap_next(input tap_state_e s, input logic tms);
    tap_state_e n;
    n = s;
    unique case (s)
      TAP_RESET:    n = tms ? TAP_RESET   : TAP_IDLE;
      TAP_IDLE:     n = tms ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_DR:   n = tms ? TAP_SEL_IR  : TAP_CAP_DR;
      TAP_CAP_DR:   n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: n = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: n = tms ? TAP_UPD_DR  : TAP_PAUSE_DR;
      TAP_PAUSE_DR: n = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: n = tms ? TAP_UPD_DR  : TAP_SHIFT_DR;
      TAP_UPD_DR:   n = tms ? TAP_SEL_DR  : TAP_IDLE;
      TAP_SEL_IR:   n = tms ? TAP_RESET   : TAP_CAP_IR;
      TAP_CAP_IR:   n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: n = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: n = tms ? TAP_UPD_IR  : TAP_PAUSE_IR;
      TAP_PAUSE_IR: n = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: n = tms ? TAP_UPD_IR  : TAP_SHIFT_IR;
      TAP_UPD_IR:   n = tms ? TAP_SEL_DR  : TAP_IDLE;
    endcase
    return n;
  endfunction

  always_ff @(posedge i_mclk)
  begin
    if (tap_block)
      tap_state_reg <= TAP_RESET;
    else if (tck_rise)
      tap_state_reg <= tap_next(tap_state_reg, pe_sync[`PE_MODE_SEL]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction and data chains

  logic [`IR_LEN-1:0] ir_q;
  logic [`IR_LEN-1:0] instr_reg;
  logic [`DR_LEN-1:0] dr_q;
  logic [`DR_LEN-1:0] dr_cap;
  logic               security_reg;
  logic               read_op;

  isp_shift #(
    .WIDTH (`IR_LEN)
  ) u_ir (
    .i_mclk     (i_mclk),
    .i_clear    (tap_block),
    .i_capture  (tck_rise && tap_state_reg == TAP_CAP_IR),
    .i_shift    (tck_rise && tap_state_reg == TAP_SHIFT_IR),
    .i_sin      (pe_sync[`PE_DATA_IN]),
    .i_cap_data (`IR_CAPTURE),
    .o_q        (ir_q)
  );

  assign read_op = (instr_reg == `OP_READ) || (instr_reg == `OP_VERIFY);

  always_comb
  begin
    dr_cap = dr_q;
    if (read_op)
      dr_cap[`DR_DATA_LSB +: `DR_DATA_W] = security_reg ? '0 : i_flash_rdata;
  end

  isp_shift #(
    .WIDTH (`DR_LEN)
  ) u_dr (
    .i_mclk     (i_mclk),
    .i_clear    (tap_block),
    .i_capture  (tck_rise && tap_state_reg == TAP_CAP_DR),
    .i_shift    (tck_rise && tap_state_reg == TAP_SHIFT_DR),
    .i_sin      (pe_sync[`PE_DATA_IN]),
    .i_cap_data (dr_cap),
    .o_q        (dr_q)
  );

  always_ff @(posedge i_mclk)
  begin
    if (tap_block || (tap_state_reg == TAP_RESET))
      instr_reg <= `OP_BYPASS;
    else if (tck_fall && tap_state_reg == TAP_UPD_IR)
      instr_reg <= ir_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // command execution at update of the data chain

  logic                 exec;
  logic                 cmd_ok;
  logic                 ext_en_reg;
  logic                 od_reg;
  logic                 disabled_seen_reg;
  logic                 error_reg;
  logic [SECTORS-1:0]   protect_reg;
  logic [`DR_SECT_W-1:0] dr_sector;
  logic                 sector_locked;

  assign exec          = tck_fall && (tap_state_reg == TAP_UPD_DR) && !tap_block;
  assign cmd_ok        = exec && isc_en_reg;
  assign dr_sector     = dr_q[`DR_SECT_LSB +: `DR_SECT_W];
  assign sector_locked = protect_reg[dr_sector];

  always_ff @(posedge i_mclk)
  begin
    if (tap_block)
    begin
      isc_en_reg <= 1'b0;
      ext_en_reg <= 1'b0;
      od_reg     <= 1'b0;
    end
    else if (exec && instr_reg == `OP_ISC_ENABLE)
    begin
      isc_en_reg <= 1'b1;
      ext_en_reg <= dr_q[`DR_EXT_EN_BIT];
      od_reg     <= dr_q[`DR_OPEN_DRAIN_BIT];
    end
    else if (cmd_ok && instr_reg == `OP_ISC_DISABLE)
    begin
      isc_en_reg <= 1'b0;
      ext_en_reg <= 1'b0;
      od_reg     <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      disabled_seen_reg <= 1'b0;
    else if (cmd_ok && instr_reg == `OP_ISC_DISABLE)
      disabled_seen_reg <= 1'b1;
    else if (cmd_ok)
      disabled_seen_reg <= 1'b0;
  end

  // a failure in the same cycle as a clear keeps the flag set
  always_ff @(posedge i_mclk)
  begin
    if (i_flash_fail)
      error_reg <= 1'b1;
    else if (i_sys_rst && (disabled_seen_reg || !i_nvm_pin_dedicate))
      error_reg <= 1'b0;
    else if (cmd_ok && instr_reg == `OP_CLEAR_ERROR)
      error_reg <= 1'b0;
  end

  // nvm images are loaded at reset; a blank part has them all zero
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      security_reg <= i_nvm_security;
      protect_reg  <= i_nvm_protect;
    end
    else if (cmd_ok && instr_reg == `OP_FULL_ERASE && !i_flash_busy)
    begin
      security_reg <= 1'b0;
      protect_reg  <= '0;
    end
    else if (cmd_ok && !security_reg && instr_reg == `OP_SET_SECURITY)
      security_reg <= 1'b1;
    else if (cmd_ok && !security_reg && instr_reg == `OP_SET_PROTECT)
      protect_reg[dr_sector] <= 1'b1;
  end

  // unknown codes, including scan-type codes, behave as bypass
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      o_flash_req <= '0;
    else
    begin
      o_flash_req.valid  <= 1'b0;
      o_flash_req.sector <= dr_sector;
      o_flash_req.addr   <= dr_q[`DR_ADDR_LSB +: `DR_ADDR_W];
      o_flash_req.data   <= dr_q[`DR_DATA_LSB +: `DR_DATA_W];
      if (cmd_ok && !i_flash_busy)
      begin
        unique case (instr_reg)
          `OP_FULL_ERASE:
          begin
            o_flash_req.valid <= 1'b1;
            o_flash_req.op    <= FOP_FULL_ERASE;
          end
          `OP_PROGRAM:
          begin
            o_flash_req.valid <= !security_reg;
            o_flash_req.op    <= FOP_PROGRAM;
          end
          `OP_SECTOR_ERASE:
          begin
            o_flash_req.valid <= !security_reg && !sector_locked;
            o_flash_req.op    <= FOP_SECTOR_ERASE;
          end
          `OP_READ, `OP_VERIFY:
          begin
            o_flash_req.valid <= !security_reg;
            o_flash_req.op    <= FOP_READ;
          end
          default:
            o_flash_req.valid <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial output and pin drive

  logic tdo_reg;
  logic tdo_drive_reg;
  logic ready;

  always_ff @(posedge i_mclk)
  begin
    if (tap_block)
    begin
      tdo_reg       <= 1'b0;
      tdo_drive_reg <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_reg       <= (tap_state_reg == TAP_SHIFT_IR) ? ir_q[0] : dr_q[0];
      tdo_drive_reg <= isc_en_reg &&
                       (tap_state_reg == TAP_SHIFT_IR || tap_state_reg == TAP_SHIFT_DR);
    end
  end

  assign ready = ~i_flash_busy;

  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst && !i_nvm_pin_dedicate)
    begin
      o_pe      <= '0;
      o_pe_oe_n <= '1;
    end
    else
    begin
      o_pe      <= i_gpio_out;
      o_pe_oe_n <= i_gpio_oe_n;
      if (jtag_on)
      begin
        o_pe[`PE_MODE_SEL]      <= 1'b0;
        o_pe_oe_n[`PE_MODE_SEL] <= 1'b1;
        o_pe[`PE_TEST_CLK]      <= 1'b0;
        o_pe_oe_n[`PE_TEST_CLK] <= 1'b1;
        o_pe[`PE_DATA_IN]       <= 1'b0;
        o_pe_oe_n[`PE_DATA_IN]  <= 1'b1;
        o_pe[`PE_DATA_OUT]      <= tdo_reg;
        o_pe_oe_n[`PE_DATA_OUT] <= ~tdo_drive_reg;
        if (ext_en_reg)
        begin
          // open drain only pulls low; a high level is left to the pull-up
          o_pe[`PE_STATUS]      <= od_reg ? 1'b0 : ready;
          o_pe_oe_n[`PE_STATUS] <= od_reg ? ready : 1'b0;
          o_pe[`PE_ERROR]       <= od_reg ? 1'b0 : ~error_reg;
          o_pe_oe_n[`PE_ERROR]  <= od_reg ? ~error_reg : 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  or_enable_a: assert property (i_pin_enable_product_term |=> &o_pe_oe_n[2:0])
    else $error("product term did not take the test pins");
  dedicate_a: assert property (i_nvm_pin_dedicate |-> o_pins_enabled)
    else $error("dedicated pins not enabled");
  rt_write_a: assert property (io_hit && i_io.wr && i_io.wdata[0] |=> o_pins_enabled ##1 &o_pe_oe_n[2:0])
    else $error("enable write did not assign pins");
  rt_clear_a: assert property (io_hit && i_io.wr && !i_io.wdata[0] |=> !rt_enable_reg)
    else $error("enable bit not cleared by write");
  release_a: assert property (!jtag_on |=> o_pe_oe_n == $past(i_gpio_oe_n))
    else $error("pins not released to general I/O");
  tdo_gate_a: assert property ($past(jtag_on) && !o_pe_oe_n[3] |-> $past(isc_en_reg, 2))
    else $error("data out driven before enable command");
  err_set_a: assert property (i_flash_fail |=> error_reg [*2] or ##1 $fell(error_reg) ##0 $past(cmd_ok))
    else $error("error flag not held after failure");
  status_mirror_a: assert property (jtag_on && ext_en_reg && !od_reg |=> o_pe[4] == !$past(i_flash_busy))
    else $error("status pin does not mirror ready");
  secure_blk_a: assert property (o_flash_req.valid && o_flash_req.op != FOP_FULL_ERASE |-> !$past(security_reg))
    else $error("command accepted while secured");
  full_erase_a: assert property (cmd_ok && instr_reg == `OP_FULL_ERASE && !i_flash_busy |=> !security_reg && protect_reg == '0)
    else $error("full erase left device secured");
  protect_a: assert property (o_flash_req.valid && o_flash_req.op == FOP_SECTOR_ERASE |-> !$past(sector_locked))
    else $error("protected sector erased");
  tdo_shift_a: assert property (tdo_drive_reg |-> $past(tap_state_reg) inside {TAP_SHIFT_IR, TAP_SHIFT_DR} || $stable(tdo_drive_reg))
    else $error("data out driven outside shift");
  ded_reset_a: assert property (disable iff (1'b0) i_sys_rst && i_nvm_pin_dedicate && !tck_rise |=> $stable(tap_state_reg))
    else $error("reset disturbed dedicated port");

  enable_c: cover property (exec && instr_reg == `OP_ISC_ENABLE);
  erase_c:  cover property (o_flash_req.valid && o_flash_req.op == FOP_FULL_ERASE);
  error_c:  cover property (jtag_on && ext_en_reg ##1 !o_pe[5] && !o_pe_oe_n[5]);
  tdo_c:    cover property (!o_pe_oe_n[3] && jtag_on);

endmodule

// ---- tb/jtag_host_model.sv ----
`timescale 1ns/10ps

// programming-cable side of the test port; the test clock idles low between frames
module jtag_host_model #(
  parameter int HALF_NS = 24
) (
  output logic      o_tms,
  output logic      o_tck,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  initial
  begin
    o_tms = 1'b1;
    o_tck = 1'b0;
    o_tdi = 1'b0;
  end

  // data changes half a period before the rising test clock, tdo sampled just before it
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v);
    o_tms = tms_v;
    o_tdi = tdi_v;
    #(HALF_NS);
    tdo_v = i_tdo;
    o_tck = 1'b1;
    #(HALF_NS);
    o_tck = 1'b0;
  endtask

  task automatic tap_reset();
    logic d;
    repeat (5) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask

  // one instruction then one 32-bit data frame, both lsb first, ending in idle
  task automatic scan(input logic [3:0] ir, input logic [31:0] dr, output logic [3:0] ir_out);
    logic d;
    #1.3;
    step(1'b1, 1'b0, d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < 4; i++)
    begin
      step(i == 3, ir[i], d);
      ir_out[i] = d;
    end
    step(1'b1, 1'b0, d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < 32; i++)
      step(i == 31, dr[i], d);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`include "isp_pin_params.svh"

module testbench;
  import isp_pin_pkg::*;
  logic       clk;
  logic       rst;
  io_req_s    io;
  logic [7:0] rdata;
  logic       ded;
  logic       pterm;
  logic       sec;
  logic [5:0] pe_pin;
  logic [5:0] pe_out;
  logic [5:0] pe_oe_n;
  logic [5:0] gpio_out;
  logic [5:0] gpio_oe_n;
  flash_req_s freq;
  flash_req_s last_req;
  logic       busy;
  logic       fail;
  logic       pins_en;
  logic [5:0] gpio_in;
  logic       tms;
  logic       tck;
  logic       tdi;
  logic [3:0] ir_cap;
  logic [7:0] rd;
  int         req_cnt;
  int         err_total;
  int         num_checks;
  logic [3:0] rows [6] = '{4'b0000, 4'b1001, 4'b0101, 4'b0011, 4'b1111, 4'b0000};

  isp_pin_ctrl dut (
    .i_mclk                    (clk),
    .i_sys_rst                 (rst),
    .i_io                      (io),
    .o_io_rdata                (rdata),
    .i_nvm_pin_dedicate        (ded),
    .i_pin_enable_product_term (pterm),
    .i_nvm_security            (sec),
    .i_nvm_protect             (32'h0000_0008),
    .i_pe                      (pe_pin),
    .o_pe                      (pe_out),
    .o_pe_oe_n                 (pe_oe_n),
    .i_gpio_out                (gpio_out),
    .i_gpio_oe_n               (gpio_oe_n),
    .o_gpio_in                 (gpio_in),
    .o_flash_req               (freq),
    .i_flash_busy              (busy),
    .i_flash_fail              (fail),
    .i_flash_rdata             (8'h5A),
    .o_pins_enabled            (pins_en)
  );

  jtag_host_model u_host (
    .o_tms (tms),
    .o_tck (tck),
    .o_tdi (tdi),
    .i_tdo (pe_pin[3])
  );

  // released pins float high through pull-ups, the host drives select, clock and data in
  assign pe_pin = (~pe_oe_n & pe_out) | (pe_oe_n & {3'b111, tdi, tck, tms});

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
    if (freq.valid === 1'b1)
    begin
      req_cnt++;
      last_req = freq;
    end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t %s got %h want %h", $time, msg, got, exp);
      err_total++;
    end
  endtask

  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    io <= '0;
  endtask

  task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    io <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    io <= '0;
    #1;
    d = rdata;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic set_busy(input logic b);
    @(posedge clk);
    busy <= b;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic run_cmd(input logic [3:0] op, input logic [31:0] dr, input int pulses,
                         input string msg);
    int n0;
    n0 = req_cnt;
    u_host.scan(op, dr, ir_cap);
    repeat (12) @(posedge clk);
    #1;
    chk(req_cnt - n0, pulses, msg);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // sized for roughly forty frames of the test port, well inside the cycle budget
    #100000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    io = '0;
    ded = 1'b0;
    pterm = 1'b0;
    sec = 1'b0;
    gpio_out = 6'h15;
    gpio_oe_n = 6'h2A;
    busy = 1'b0;
    fail = 1'b0;
    req_cnt = 0;
    err_total = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    io_rd(8'hC7, rd);
    chk(rd, 8'h00, "enable register reset value");
    $display("test reset done");

    foreach (rows[i])
    begin
      @(posedge clk);
      ded <= rows[i][3];
      pterm <= rows[i][2];
      io_wr(8'hC7, {7'h00, rows[i][1]});
      repeat (3) @(posedge clk);
      #1;
      chk(pins_en, rows[i][0], "pin enable sources");
      chk(gpio_in, pe_pin, "synchronised pin levels");
      if (rows[i][0])
        chk(pe_oe_n[3:0], 4'hF, "port pins are inputs");
      else
        chk({pe_oe_n[3:0], pe_out[3:0]}, {gpio_oe_n[3:0], gpio_out[3:0]}, "gpio release");
      io_rd(8'hC7, rd);
      chk(rd[1:0], {rows[i][0], rows[i][1]}, "enable readback");
    end
    io_wr(8'hC6, 8'h01);
    io_rd(8'hC6, rd);
    chk({pins_en, rd}, 9'h000, "unmapped access ignored");
    $display("test enable table done");

    io_wr(8'hC7, 8'h01);
    u_host.tap_reset();
    run_cmd(`OP_ISC_ENABLE, 32'h1, 0, "enable command");
    chk(ir_cap, 4'hF, "data out released before enable");
    chk({pe_oe_n[4:3], pe_out[4]}, 3'b011, "status on, data out idle");
    set_busy(1'b1);
    chk(pe_out[4], 1'b0, "status low while busy");
    set_busy(1'b0);
    run_cmd(`OP_PROGRAM, {16'h1234, 3'b000, 5'd7, 8'hA5}, 1, "program accepted");
    chk(ir_cap, `IR_CAPTURE, "instruction capture");
    chk({last_req.op, last_req.addr, last_req.data}, {FOP_PROGRAM, 16'h1234, 8'hA5},
        "program request");
    $display("test channel done");

    @(posedge clk);
    fail <= 1'b1;
    @(posedge clk);
    fail <= 1'b0;
    repeat (40) @(posedge clk);
    #1;
    chk(pe_out[5], 1'b0, "error held low");
    run_cmd(`OP_CLEAR_ERROR, 32'h0, 0, "clear error");
    chk(pe_out[5], 1'b1, "error cleared");
    run_cmd(`OP_ISC_ENABLE, 32'h3, 0, "open drain enable");
    chk(pe_oe_n[5:4], 2'b11, "open drain high released");
    set_busy(1'b1);
    chk({pe_oe_n[4], pe_out[4]}, 2'b00, "open drain pulls low");
    set_busy(1'b0);
    $display("test extensions done");

    run_cmd(`OP_SECTOR_ERASE, {16'h0, 3'b000, 5'd3, 8'h00}, 0, "protected erase");
    run_cmd(`OP_SECTOR_ERASE, {16'h0, 3'b000, 5'd4, 8'h00}, 1, "open erase");
    chk(last_req.sector, 5'd4, "erase sector");
    $display("test protect done");

    @(posedge clk);
    sec <= 1'b1;
    do_reset();
    io_rd(8'hC7, rd);
    chk({pins_en, pe_oe_n[4], rd}, {1'b0, gpio_oe_n[4], 8'h00}, "reset drops runtime enable");
    @(posedge clk);
    sec <= 1'b0;
    io_wr(8'hC7, 8'h01);
    u_host.tap_reset();
    run_cmd(`OP_ISC_ENABLE, 32'h1, 0, "enable secured");
    run_cmd(`OP_PROGRAM, 32'h0000_0011, 0, "secured program");
    run_cmd(`OP_SECTOR_ERASE, {16'h0, 3'b000, 5'd4, 8'h00}, 0, "secured erase");
    run_cmd(`OP_FULL_ERASE, 32'h0, 1, "full erase accepted");
    chk(last_req.op, FOP_FULL_ERASE, "full erase request");
    run_cmd(`OP_PROGRAM, 32'h0000_0022, 1, "program after erase");
    $display("test security done");

    @(posedge clk);
    ded <= 1'b1;
    do_reset();
    chk({pins_en, pe_oe_n[4]}, 2'b10, "dedicated port survives reset");
    run_cmd(`OP_PROGRAM, 32'h0000_0033, 1, "tap alive after reset");
    $display("test dedicated done");
    finish_test();
  end
endmodule
